// File: rtl/pmt_map.svh
// Register map, field positions, reset values and timing counts of the period match timer
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH
// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define PMT_IDX_PENDING 8'h0c
`define PMT_IDX_COUNT 8'h11
`define PMT_IDX_CTRL 8'h12
`define PMT_IDX_IRQEN 8'h8c
`define PMT_IDX_PERIOD 8'h92
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMT_MATCH_FLAG_BIT 1
`define PMT_RUN_BIT 2
`define PMT_OUTDIV_LSB 3
`define PMT_OUTDIV_MSB 6
`define PMT_INDIV_LSB 0
`define PMT_INDIV_MSB 1
`define PMT_CTRL_MASK 8'h7f
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_CTRL 8'h00
`define PMT_RST_FLAGS 8'h00
// ----------------------------------------
// Timing counts: instruction-clock divider last value in reference-clock cycles, prescaler last values in instruction-clock cycles
// ----------------------------------------
`define PMT_ICLK_DIV 2'h3
`define PMT_PRE_LAST_DIV4 4'h3
`define PMT_PRE_LAST_DIV16 4'hf
`endif

// File: rtl/pmt_pkg.sv
// Types shared by the period match timer
`default_nettype none
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_PRE_DIV1 = 2'b00,
    PMT_PRE_DIV4 = 2'b01,
    PMT_PRE_DIV16A = 2'b10,
    PMT_PRE_DIV16B = 2'b11
  } pmt_prediv_e;
  typedef logic [7:0] pmt_byte_t;
endpackage
`default_nettype wire

// File: rtl/pmt_wb_slave.sv
// Classic Wishbone slave front end of the period match timer
`timescale 1ns/1ps
`default_nettype none
module pmt_wb_slave
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  // Register side
  output logic acc_o,
  output logic acc_we_o,
  output logic [7:0] acc_idx_o,
  output logic acc_lane0_o
);
  logic ack_reg;
  logic ack_next;

  // ----------------------------------------
  // One-wait-state acknowledge
  // ----------------------------------------
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  assign wb_ack_o = ack_reg;
  // Access applied on the edge that raises ack, so read data and read-clear agree
  assign acc_o = ack_next;
  assign acc_we_o = wb_we_i;
  assign acc_idx_o = wb_adr_i[9:2];
  assign acc_lane0_o = wb_sel_i[0];
endmodule
`default_nettype wire

// File: rtl/pmt_timer.sv
// Period match timer top: counter, prescaler, postscaler, flags and registers
// ----------------------------------------
// How it works
// - Counter counts up, wraps to zero after match
// - Period register read/write, resets to all ones
// - Counter register read/write, reset to zero
// - Prescaler divides by one, four or sixteen
// - Postscaler divides matches by field plus one
// - Postscaler terminal count sets sticky match flag
// - Counter or control write clears both scalers
// - Control write leaves counter value alone
// - Run bit enables counting, clear stops it
// - Pre-postscaler match pulse goes to serial port
// - Counter value and match go to PWM
// - Control top bit reads zero, fields reset zero
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module pmt_timer
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq,
  // Serial port and PWM time base
  output logic sync_serial_port_shift_tick,
  output logic capture_compare_pwm_unit_match,
  output logic [7:0] capture_compare_pwm_unit_count
);
  logic acc;
  logic acc_we;
  logic [7:0] acc_idx;
  logic acc_lane0;
  logic wr;
  logic rd;
  logic [7:0] wdat;

  logic [1:0] iclk_reg, iclk_next;
  logic [3:0] pre_reg, pre_next;
  logic [3:0] post_reg, post_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] period_reg, period_next;
  logic [6:0] ctrl_reg, ctrl_next;
  logic flag_reg, flag_next;
  logic irqen_reg, irqen_next;
  logic [31:0] rdat_reg, rdat_next;
  logic match_reg, match_next;

  logic iclk_tick;
  logic pre_tick;
  logic match_now;
  logic post_term;
  logic run;
  logic [3:0] pre_last;
  logic [3:0] post_last;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  pmt_wb_slave u_wb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .acc_o(acc),
    .acc_we_o(acc_we),
    .acc_idx_o(acc_idx),
    .acc_lane0_o(acc_lane0)
  );

  assign wr = acc & acc_we & acc_lane0;
  assign rd = acc & ~acc_we;
  assign wdat = wb_dat_i[7:0];

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    case (sel)
      PMT_PRE_DIV1: pre_limit = 4'h0;
      PMT_PRE_DIV4: pre_limit = `PMT_PRE_LAST_DIV4;
      default: pre_limit = `PMT_PRE_LAST_DIV16;
    endcase
  endfunction

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  assign run = ctrl_reg[`PMT_RUN_BIT];
  assign pre_last = pre_limit(ctrl_reg[`PMT_INDIV_MSB:`PMT_INDIV_LSB]);
  assign post_last = ctrl_reg[`PMT_OUTDIV_MSB:`PMT_OUTDIV_LSB];
  assign iclk_tick = (iclk_reg == `PMT_ICLK_DIV);
  assign pre_tick = run & iclk_tick & (pre_reg == pre_last);
  assign match_now = pre_tick & (count_reg == period_reg);
  assign post_term = match_now & (post_reg == post_last);

  always_comb begin
    iclk_next = iclk_reg + 2'h1;
    pre_next = pre_reg;
    post_next = post_reg;
    count_next = count_reg;
    match_next = match_now;
    if (run && iclk_tick) begin
      pre_next = (pre_reg == pre_last) ? 4'h0 : pre_reg + 4'h1;
    end
    if (pre_tick) begin
      count_next = match_now ? 8'h00 : count_reg + 8'h01;
    end
    if (match_now) begin
      post_next = post_term ? 4'h0 : post_reg + 4'h1;
    end
    if (wr && hit(acc_idx, `PMT_IDX_COUNT)) begin
      count_next = wdat;
      pre_next = 4'h0;
      post_next = 4'h0;
    end
    if (wr && hit(acc_idx, `PMT_IDX_CTRL)) begin
      pre_next = 4'h0;
      post_next = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      iclk_reg <= 2'h0;
      pre_reg <= 4'h0;
      post_reg <= 4'h0;
      count_reg <= `PMT_RST_COUNT;
      match_reg <= 1'b0;
    end else begin
      iclk_reg <= iclk_next;
      pre_reg <= pre_next;
      post_reg <= post_next;
      count_reg <= count_next;
      match_reg <= match_next;
    end
  end

  // ----------------------------------------
  // Registers and flags
  // ----------------------------------------
  always_comb begin
    period_next = period_reg;
    ctrl_next = ctrl_reg;
    irqen_next = irqen_reg;
    flag_next = flag_reg;
    rdat_next = 32'h0;
    if (rd && hit(acc_idx, `PMT_IDX_PENDING)) begin
      flag_next = 1'b0;
    end
    if (wr && hit(acc_idx, `PMT_IDX_PENDING)) begin
      flag_next = wdat[`PMT_MATCH_FLAG_BIT];
    end
    if (post_term) begin
      flag_next = 1'b1;
    end
    if (wr && hit(acc_idx, `PMT_IDX_PERIOD)) begin
      period_next = wdat;
    end
    if (wr && hit(acc_idx, `PMT_IDX_CTRL)) begin
      ctrl_next = wdat[6:0];
    end
    if (wr && hit(acc_idx, `PMT_IDX_IRQEN)) begin
      irqen_next = wdat[`PMT_MATCH_FLAG_BIT];
    end
    if (acc_idx == `PMT_IDX_PENDING) begin
      rdat_next[`PMT_MATCH_FLAG_BIT] = flag_reg;
    end else if (acc_idx == `PMT_IDX_COUNT) begin
      rdat_next[7:0] = count_reg;
    end else if (acc_idx == `PMT_IDX_CTRL) begin
      rdat_next[7:0] = {1'b0, ctrl_reg};
    end else if (acc_idx == `PMT_IDX_IRQEN) begin
      rdat_next[`PMT_MATCH_FLAG_BIT] = irqen_reg;
    end else if (acc_idx == `PMT_IDX_PERIOD) begin
      rdat_next[7:0] = period_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      period_reg <= `PMT_RST_PERIOD;
      ctrl_reg <= 7'(`PMT_RST_CTRL);
      irqen_reg <= 1'b0;
      flag_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      period_reg <= period_next;
      ctrl_reg <= ctrl_next;
      irqen_reg <= irqen_next;
      flag_reg <= flag_next;
      rdat_reg <= rdat_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o = rdat_reg;
  assign irq = flag_reg & irqen_reg;
  assign sync_serial_port_shift_tick = match_reg;
  assign capture_compare_pwm_unit_match = match_reg;
  assign capture_compare_pwm_unit_count = count_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_match;
    match_now;
  endsequence

  sequence s_pend_read;
    rd && hit(acc_idx, `PMT_IDX_PENDING) && !post_term;
  endsequence

  sequence s_flag_raise;
    post_term && irqen_reg && !(wr && hit(acc_idx, `PMT_IDX_IRQEN));
  endsequence

  property p_wrap;
    @(posedge ref_clk) disable iff (!resetn)
    s_match ##0 !(wr && hit(acc_idx, `PMT_IDX_COUNT)) |=> count_reg == 8'h00;
  endproperty

  property p_read_clear;
    @(posedge ref_clk) disable iff (!resetn)
    s_pend_read |=> !flag_reg;
  endproperty

  property p_irq_raise;
    @(posedge ref_clk) disable iff (!resetn)
    s_flag_raise |=> irq;
  endproperty

  AST_WRAP: assert property (p_wrap)
    else $error("Counter did not wrap on match");

  AST_PERIOD_RST: assert property (@(posedge ref_clk)
    $rose(resetn) |-> period_reg == `PMT_RST_PERIOD)
    else $error("Period not all ones after reset");

  AST_RST_ZERO: assert property (@(posedge ref_clk)
    $rose(resetn) |-> count_reg == `PMT_RST_COUNT && ctrl_reg == 7'h00 &&
    pre_reg == 4'h0 && post_reg == 4'h0)
    else $error("Timer state not cleared by reset");

  AST_COUNT_WR: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr && hit(acc_idx, `PMT_IDX_COUNT) |=> count_reg == $past(wdat))
    else $error("Counter write lost");

  AST_DIV16: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_tick && ctrl_reg[1] && !wr |-> ##1 !pre_tick [*8] ##0 !pre_tick [*7])
    else $error("Prescaler 16 ticked early");

  AST_PRE_RANGE: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_reg <= pre_last)
    else $error("Prescaler count beyond its limit");

  AST_POST: assert property (@(posedge ref_clk) disable iff (!resetn)
    post_reg <= post_last)
    else $error("Postscaler count beyond its limit");

  AST_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
    post_term |=> flag_reg)
    else $error("Match flag not set");

  AST_READ_CLR: assert property (p_read_clear)
    else $error("Match flag not cleared by read");

  AST_SCALER_CLR: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr && hit(acc_idx, `PMT_IDX_CTRL) |=> pre_reg == 4'h0 && post_reg == 4'h0)
    else $error("Scalers not cleared by control write");

  AST_PRE_CLR: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr && hit(acc_idx, `PMT_IDX_COUNT) |=> pre_reg == 4'h0 && post_reg == 4'h0)
    else $error("Scalers not cleared by counter write");

  AST_CTRL_KEEP: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr && hit(acc_idx, `PMT_IDX_CTRL) && !pre_tick |=> $stable(count_reg))
    else $error("Control write changed counter");

  AST_STOP: assert property (@(posedge ref_clk) disable iff (!resetn)
    !run && !wr |=> $stable(count_reg))
    else $error("Counter moved while stopped");

  AST_MATCH_OUT: assert property (@(posedge ref_clk) disable iff (!resetn)
    match_now |=> sync_serial_port_shift_tick && capture_compare_pwm_unit_match)
    else $error("Match pulse not offered");

  AST_CTRL_TOP: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && hit(acc_idx, `PMT_IDX_CTRL) |=> wb_dat_o == {25'h0, $past(ctrl_reg)})
    else $error("Control read data wrong");

  AST_IRQ: assert property (p_irq_raise)
    else $error("Interrupt not raised for enabled flag");

  AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge longer than one cycle");
endmodule
`default_nettype wire

// File: dv/test_period_match_timer8.sv
// Self-checking testbench of the period match timer
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module test_period_match_timer8;
  import pmt_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq;
  logic sync_serial_port_shift_tick;
  logic capture_compare_pwm_unit_match;
  logic [7:0] capture_compare_pwm_unit_count;
  int fails = 0;
  int n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  pmt_timer uut (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .sync_serial_port_shift_tick(sync_serial_port_shift_tick),
    .capture_compare_pwm_unit_match(capture_compare_pwm_unit_match),
    .capture_compare_pwm_unit_count(capture_compare_pwm_unit_count)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task xfer(input logic we, input logic [7:0] idx, input pmt_byte_t wd, output pmt_byte_t rd);
    int i;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {22'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o[7:0];
    if (!we) chk("read upper bits", 32'h0, {8'h0, wb_dat_o[31:8]});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input pmt_byte_t wd);
    pmt_byte_t d;
    xfer(1'b1, idx, wd, d);
  endtask
  task rd_chk(input string nm, input logic [7:0] idx, input pmt_byte_t exp);
    pmt_byte_t d;
    xfer(1'b0, idx, 8'h00, d);
    chk(nm, {24'h0, exp}, {24'h0, d});
  endtask
  task wait_tick(output int gap);
    gap = 0;
    do begin
      @(posedge ref_clk);
      gap++;
    end while (capture_compare_pwm_unit_match !== 1'b1 && gap < 5000);
    chk("match seen", 32'h1, {31'h0, capture_compare_pwm_unit_match});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd_chk("pending reset", `PMT_IDX_PENDING, 8'h00);
    rd_chk("count reset", `PMT_IDX_COUNT, 8'h00);
    rd_chk("control reset", `PMT_IDX_CTRL, 8'h00);
    rd_chk("enables reset", `PMT_IDX_IRQEN, 8'h00);
    rd_chk("period reset", `PMT_IDX_PERIOD, 8'hff);
    rd_chk("unmapped read", 8'h20, 8'h00);
  endtask
  task t_regs;
    wr(`PMT_IDX_CTRL, 8'hff);
    rd_chk("control top bit", `PMT_IDX_CTRL, 8'h7f);
    wr(`PMT_IDX_CTRL, 8'h00);
    wr(`PMT_IDX_PERIOD, 8'h5a);
    rd_chk("period rw", `PMT_IDX_PERIOD, 8'h5a);
    wr(`PMT_IDX_COUNT, 8'h33);
    rd_chk("count rw", `PMT_IDX_COUNT, 8'h33);
    wb_sel_i <= 4'he;
    wr(`PMT_IDX_COUNT, 8'h77);
    wb_sel_i <= 4'hf;
    rd_chk("count sel0 ignored", `PMT_IDX_COUNT, 8'h33);
  endtask
  task t_prescale;
    int g;
    int dv;
    wr(`PMT_IDX_PERIOD, 8'h03);
    wr(`PMT_IDX_COUNT, 8'h00);
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
      wr(`PMT_IDX_CTRL, 8'h04 | c[7:0]);
      wait_tick(g);
      chk("count at match", 32'h0, {24'h0, capture_compare_pwm_unit_count});
      wait_tick(g);
      chk("match gap", 16 * dv, g);
      chk("shift tick", 32'h1, {31'h0, sync_serial_port_shift_tick});
    end
  endtask
  task t_stop;
    pmt_byte_t d;
    wr(`PMT_IDX_CTRL, 8'h00);
    wr(`PMT_IDX_COUNT, 8'h55);
    repeat (100) @(posedge ref_clk);
    rd_chk("count stopped", `PMT_IDX_COUNT, 8'h55);
    wr(`PMT_IDX_CTRL, 8'h03);
    rd_chk("count after control write", `PMT_IDX_COUNT, 8'h55);
    wr(`PMT_IDX_PERIOD, 8'hff);
    wr(`PMT_IDX_CTRL, 8'h04);
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, `PMT_IDX_COUNT, 8'h00, d);
    chk("count runs", 32'h1, {31'h0, d !== 8'h55});
  endtask
  task t_post(input logic [3:0] n);
    int g;
    wr(`PMT_IDX_IRQEN, 8'h02);
    wr(`PMT_IDX_PERIOD, 8'h00);
    wr(`PMT_IDX_COUNT, 8'h00);
    wr(`PMT_IDX_CTRL, {1'b0, n, 3'b111});
    wr(`PMT_IDX_PENDING, 8'h00);
    rd_chk("pending cleared", `PMT_IDX_PENDING, 8'h00);
    for (int k = 1; k <= n + 1; k++) begin
      wait_tick(g);
      repeat (3) @(posedge ref_clk);
      chk("irq after matches", {31'h0, k == n + 1}, {31'h0, irq});
    end
    rd_chk("flag set", `PMT_IDX_PENDING, 8'h02);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("flag read clear", `PMT_IDX_PENDING, 8'h00);
    wr(`PMT_IDX_IRQEN, 8'h00);
    for (int k = 1; k <= n + 1; k++) wait_tick(g);
    repeat (3) @(posedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("flag while masked", `PMT_IDX_PENDING, 8'h02);
  endtask
  task t_rerst;
    wr(`PMT_IDX_PERIOD, 8'h12);
    wr(`PMT_IDX_COUNT, 8'h34);
    wr(`PMT_IDX_IRQEN, 8'h02);
    wr(`PMT_IDX_CTRL, 8'h7c);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk("period re-reset", `PMT_IDX_PERIOD, 8'hff);
    rd_chk("count re-reset", `PMT_IDX_COUNT, 8'h00);
    rd_chk("control re-reset", `PMT_IDX_CTRL, 8'h00);
    rd_chk("enables re-reset", `PMT_IDX_IRQEN, 8'h00);
    rd_chk("pending re-reset", `PMT_IDX_PENDING, 8'h00);
    chk("irq re-reset", 32'h0, {31'h0, irq});
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_prescale;
    t_stop;
    t_post(4'h0);
    t_post(4'h5);
    t_post(4'hf);
    t_rerst;
    summarize;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    summarize;
  end
endmodule
`default_nettype wire
